// >>> dbt_trace_regs.sv
// debug breakpoint, forced reset and trace registers
`timescale 1ns/10ps
`include "dbt_params.svh"
module dbt_trace_regs #(
   parameter int DEPTH = `DBT_DEPTH,
   parameter int CW    = $clog2(DEPTH) + 1
) (
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic [3:0]    regSel,
   input  wire logic          regWr,
   input  wire logic          regRd,
   input  wire logic [7:0]    regWdata,
   output logic      [7:0]    regRdata,
   input  wire logic          bdcSel,
   input  wire logic          bdcWr,
   input  wire logic          bdcRd,
   input  wire logic [15:0]   bdcWdata,
   output logic      [15:0]   bdcRdata,
   input  wire logic          serialBkptEnable,
   input  wire logic          bkptKindSelect,
   input  wire logic          mcuSecure,
   input  wire logic          trgEventOnly,
   input  wire logic          trgBegin,
   input  wire logic          trgOpQualify,
   input  wire logic          cpuBusCycle,
   input  wire logic          cpuRw,
   input  wire logic          cpuOpFetch,
   input  wire logic [15:0]   cpuAddr,
   input  wire logic [7:0]    cpuData,
   output logic               cpuBreakForce,
   output logic               cpuBreakTag,
   output logic               mcuResetReq,
   output logic               runActive,
   output logic      [CW-1:0] fifoCount
);
   // address match with optional read/write qualification
   function automatic logic cmpHit(input logic [15:0] val,
                                   input logic [15:0] addr,
                                   input logic        cyc,
                                   input logic        rw,
                                   input logic        dirEn,
                                   input logic        dir);
      cmpHit = cyc & (addr == val) & (~dirEn | (rw == dir));
   endfunction : cmpHit

   logic [7:0]          compAHi;
   logic [7:0]          compALo;
   logic [7:0]          compBHi;
   logic [7:0]          compBLo;
   logic                modEnable;
   logic                tagSel;
   logic                brkEnable;
   logic                comp_a_direction;
   logic                comp_a_direction_enable;
   logic                comp_b_direction;
   logic                comp_b_direction_enable;
   dbt_pkg::dbt_run_t   run;
   dbt_pkg::dbt_run_t   next_run;
   dbt_pkg::dbt_word_t  bkptAddr;
   dbt_pkg::dbt_word_t  lastOpAddr;
   logic [CW-1:0]       leftWords;

   dbt_fifo_if #(.W(`DBT_WORD), .CW(CW)) fq ();

   dbt_fifo #(
      .W     (`DBT_WORD),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .f       (fq)
   );

   // register decode over the seven debug bytes
   // application map
   wire wrCAH = regWr & (regSel == `DBT_IDX_CAH);
   wire wrCAL = regWr & (regSel == `DBT_IDX_CAL);
   wire wrCBH = regWr & (regSel == `DBT_IDX_CBH);
   wire wrCBL = regWr & (regSel == `DBT_IDX_CBL);
   wire wrCtl = regWr & (regSel == `DBT_IDX_CTL);
   wire rdLow = regRd & (regSel == `DBT_IDX_FL);
   wire armed = (run != dbt_pkg::RUN_IDLE);
   wire cmpWrOk = ~armed;

   // comparator matches on the cpu bus
   // 16-bit compare
   wire matchA = cmpHit({compAHi, compALo}, cpuAddr, cpuBusCycle, cpuRw, comp_a_direction_enable, comp_a_direction);
   wire matchB = cmpHit({compBHi, compBLo}, cpuAddr, cpuBusCycle, cpuRw, comp_b_direction_enable, comp_b_direction);
   // opcode qualified trigger for fifo sequencing
   wire trigHit = matchA & (~trgOpQualify | cpuOpFetch);

   // control write effects
   // secure blocks enable
   wire next_enable = wrCtl ? (regWdata[`DBT_EN] & (~mcuSecure | modEnable))
                            : modEnable;
   wire runStart = wrCtl & regWdata[`DBT_ARM] & next_enable & ~armed;
   wire runStop  = wrCtl & ~(regWdata[`DBT_ARM] & next_enable);

   // capture path into the fifo
   wire fifoFull  = (fq.count == CW'(DEPTH));
   wire lastSlot  = (fq.count == CW'(DEPTH - 1));
   wire endPush   = (run == dbt_pkg::RUN_END) & cpuOpFetch & ~trigHit;
   wire begPush   = (run == dbt_pkg::RUN_BEGIN) & (trgEventOnly ? matchB : cpuOpFetch);
   wire capPush   = endPush | begPush;
   wire [15:0] capData = trgEventOnly ? {`DBT_ZERO8, cpuData} : cpuAddr;
   wire fillDone  = begPush & lastSlot;
   wire endDone   = (run == dbt_pkg::RUN_END) & trigHit;
   // profiling store on idle low read
   wire profPush  = rdLow & ~armed;
   // pop once eight are primed or run data is left
   wire profPop   = profPush & fq.outValid & (fifoFull | (leftWords != '0));
   wire circPop   = endPush & fifoFull;

   assign fq.inValid  = capPush | profPush;
   assign fq.inData   = profPush ? lastOpAddr : capData;
   assign fq.outReady = profPop | circPop;
   assign fq.flush    = runStart;

   // break request sources
   // comparator a match in an end run or begin full
   wire dbgBreak = brkEnable & (((run == dbt_pkg::RUN_END) & matchA) | fillDone);
   wire bdcHit = serialBkptEnable & cpuBusCycle & (cpuAddr == bkptAddr);
   wire next_force = (dbgBreak & ~tagSel) | (bdcHit & bkptKindSelect);
   wire next_tag   = (dbgBreak & tagSel) | (bdcHit & ~bkptKindSelect);

   // read data selection
   wire [15:0] head = fq.outValid ? fq.outData : `DBT_ZERO16;
   wire [7:0] fifoHi = trgEventOnly ? `DBT_ZERO8 : head[15:8];
   wire [7:0] ctlRd  = {modEnable, armed, tagSel, brkEnable, comp_a_direction, comp_a_direction_enable, comp_b_direction, comp_b_direction_enable};
   wire [7:0] rdMux =
      (regSel == `DBT_IDX_CAH) ? compAHi :
      (regSel == `DBT_IDX_CAL) ? compALo :
      (regSel == `DBT_IDX_CBH) ? compBHi :
      (regSel == `DBT_IDX_CBL) ? compBLo :
      (regSel == `DBT_IDX_FH)  ? fifoHi  :
      (regSel == `DBT_IDX_FL)  ? head[7:0] :
      (regSel == `DBT_IDX_CTL) ? ctlRd   : `DBT_ZERO8;

   // run sequencing
   always_comb begin
      next_run = run;
      unique case (run)
         dbt_pkg::RUN_IDLE: begin
            if (runStart) begin
               if (trgEventOnly) next_run = dbt_pkg::RUN_BEGIN;
               else if (trgBegin) next_run = dbt_pkg::RUN_WAIT;
               else next_run = dbt_pkg::RUN_END;
            end
         end
         dbt_pkg::RUN_WAIT: begin
            if (trigHit) next_run = dbt_pkg::RUN_BEGIN;
         end
         dbt_pkg::RUN_END: begin
            if (endDone) next_run = dbt_pkg::RUN_IDLE;
         end
         dbt_pkg::RUN_BEGIN: begin
            if (fillDone) next_run = dbt_pkg::RUN_IDLE;
         end
      endcase
      if (runStop) next_run = dbt_pkg::RUN_IDLE;
   end

   // comparator value registers
   // reset and write lock
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         compAHi <= `DBT_ZERO8;
         compALo <= `DBT_ZERO8;
         compBHi <= `DBT_ZERO8;
         compBLo <= `DBT_ZERO8;
      end else begin
         if (wrCAH & cmpWrOk) compAHi <= regWdata;
         if (wrCAL & cmpWrOk) compALo <= regWdata;
         if (wrCBH & cmpWrOk) compBHi <= regWdata;
         if (wrCBL & cmpWrOk) compBLo <= regWdata;
      end
   end

   // control register and run state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         modEnable <= 1'b0;
         tagSel    <= 1'b0;
         brkEnable <= 1'b0;
         comp_a_direction       <= 1'b0;
         comp_a_direction_enable     <= 1'b0;
         comp_b_direction       <= 1'b0;
         comp_b_direction_enable     <= 1'b0;
         run       <= dbt_pkg::RUN_IDLE;
      end else begin
         modEnable <= next_enable;
         run       <= next_run;
         if (wrCtl) begin
            tagSel    <= regWdata[`DBT_TAG];
            brkEnable <= regWdata[`DBT_BRK];
            comp_a_direction       <= regWdata[`DBT_RWA];
            comp_a_direction_enable     <= regWdata[`DBT_COMP_A_DIRECTION_ENABLE];
            comp_b_direction       <= regWdata[`DBT_RWB];
            comp_b_direction_enable     <= regWdata[`DBT_COMP_B_DIRECTION_ENABLE];
         end
      end
   end

   // occupancy after this cycle's push and pop, so the ending push is counted
   wire [CW-1:0] next_count = fq.count + CW'(fq.inValid & fq.inReady)
                              - CW'(fq.outValid & fq.outReady);

   // words left over from the last run, drained before priming
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) leftWords <= '0;
      else if (armed & (next_run == dbt_pkg::RUN_IDLE)) leftWords <= next_count;
      else if (profPop & (leftWords != '0)) leftWords <= leftWords - 1'b1;
   end

   // most recent opcode fetch address
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) lastOpAddr <= `DBT_ZERO16;
      else if (cpuOpFetch) lastOpAddr <= cpuAddr;
   end

   // serial debug port: breakpoint and forced reset
   // serial-only breakpoint register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bkptAddr    <= `DBT_ZERO16;
         bdcRdata    <= `DBT_ZERO16;
         mcuResetReq <= 1'b0;
      end else begin
         if (bdcWr & (bdcSel == `DBT_BDC_BKPT)) bkptAddr <= bdcWdata;
         if (bdcRd) bdcRdata <= (bdcSel == `DBT_BDC_BKPT) ? bkptAddr : `DBT_ZERO16;
         mcuResetReq <= bdcWr & (bdcSel == `DBT_BDC_FRC) & bdcWdata[`DBT_FRC_BIT];
      end
   end

   // registered outputs toward cpu and software
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdata      <= `DBT_ZERO8;
         cpuBreakForce <= 1'b0;
         cpuBreakTag   <= 1'b0;
         runActive     <= 1'b0;
         fifoCount     <= '0;
      end else begin
         if (regRd) regRdata <= rdMux;
         cpuBreakForce <= next_force;
         cpuBreakTag   <= next_tag;
         runActive     <= (next_run != dbt_pkg::RUN_IDLE);
         fifoCount     <= fq.count;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   compLock_a: assert property (armed && wrCAH |=> $stable(compAHi))
      else $error("comparator byte changed while armed");
   compLockB_a: assert property (armed && wrCBL |=> $stable(compBLo))
      else $error("comparator b byte changed while armed");
   frcRead_a: assert property (regRd && regSel == `DBT_IDX_FRC |=> regRdata == `DBT_ZERO8)
      else $error("force reset read not zero");
   resetReq_a: assert property (
      bdcWr && bdcSel == `DBT_BDC_FRC && bdcWdata[`DBT_FRC_BIT] |=> mcuResetReq)
      else $error("forced reset not requested");
   bkptWrite_a: assert property (
      bdcWr && bdcSel == `DBT_BDC_BKPT |=> bkptAddr == $past(bdcWdata))
      else $error("breakpoint address not written");
   secureEn_a: assert property (mcuSecure && !modEnable |=> !modEnable)
      else $error("enable set while secure");
   fifoHigh_a: assert property (
      regRd && regSel == `DBT_IDX_FH && trgEventOnly |=> regRdata == `DBT_ZERO8)
      else $error("fifo high byte not zero in event-only");
   fifoHold_a: assert property (
      regRd && regSel == `DBT_IDX_FH && !armed |=> $stable(fq.count))
      else $error("fifo moved on a high byte read");
   lowByte_a: assert property (
      begPush && trgEventOnly |-> fq.inData[15:8] == `DBT_ZERO8)
      else $error("event capture stored a high byte");
   armedHold_a: assert property (armed && rdLow && !capPush |=> $stable(fq.count))
      else $error("fifo advanced while armed");
   profStore_a: assert property (
      rdLow && !armed |-> fq.inValid && fq.inData == lastOpAddr)
      else $error("idle low read did not store opcode address");
   fifoDepth_a: assert property (fq.count <= CW'(DEPTH))
      else $error("fifo holds more than its depth");
   runStart_a: assert property (
      !armed && wrCtl && regWdata[`DBT_ARM] && next_enable |=> runActive && armed)
      else $error("run did not start");
   stopRun_a: assert property (wrCtl && !regWdata[`DBT_ARM] |=> !runActive)
      else $error("run did not stop on write");
   forceBrk_a: assert property (
      brkEnable && !tagSel && run == dbt_pkg::RUN_END && matchA |=> cpuBreakForce)
      else $error("force break missing");
   tagBrk_a: assert property (
      brkEnable && tagSel && run == dbt_pkg::RUN_END && matchA |=> cpuBreakTag)
      else $error("tag break missing");
   fullBrk_a: assert property (
      brkEnable && fillDone |=> cpuBreakForce || cpuBreakTag)
      else $error("no break on full begin trace");
   dirA_a: assert property (comp_a_direction_enable && cpuRw != comp_a_direction |-> !matchA)
      else $error("comparator a matched wrong direction");
   dirB_a: assert property (comp_b_direction_enable && cpuRw != comp_b_direction |-> !matchB)
      else $error("comparator b matched wrong direction");
   noBreak_a: assert property (
      !brkEnable && !serialBkptEnable |=> !cpuBreakForce && !cpuBreakTag)
      else $error("break raised while breaks disabled");
   bkptHit_a: assert property (
      serialBkptEnable && bkptKindSelect && cpuBusCycle && cpuAddr == bkptAddr
      |=> cpuBreakForce)
      else $error("serial breakpoint missed");
   fillEnd_a: assert property (
      fillDone && !runStop |=> !runActive && run == dbt_pkg::RUN_IDLE)
      else $error("begin run did not end on full");
   endTrig_a: assert property (run == dbt_pkg::RUN_END && trigHit |=> !runActive)
      else $error("end run did not end on trigger");
endmodule : dbt_trace_regs

// >>> dbt_params.svh
// register indices, field positions and fixed values of the debug trace block
`ifndef DBT_PARAMS_SVH
`define DBT_PARAMS_SVH
`define DBT_IDX_CAH   4'h0
`define DBT_IDX_CAL   4'h1
`define DBT_IDX_CBH   4'h2
`define DBT_IDX_CBL   4'h3
`define DBT_IDX_FH    4'h4
`define DBT_IDX_FL    4'h5
`define DBT_IDX_CTL   4'h6
`define DBT_IDX_FRC   4'h9
`define DBT_EN        7
`define DBT_ARM       6
`define DBT_TAG       5
`define DBT_BRK       4
`define DBT_RWA       3
`define DBT_COMP_A_DIRECTION_ENABLE     2
`define DBT_RWB       1
`define DBT_COMP_B_DIRECTION_ENABLE     0
`define DBT_FRC_BIT   0
`define DBT_ZERO8     8'h00
`define DBT_ZERO16    16'h0000
`define DBT_BDC_BKPT  1'b0
`define DBT_BDC_FRC   1'b1
`define DBT_DEPTH     8
`define DBT_WORD      16
`endif

// >>> dbt_pkg.sv
// types shared by the debug trace block
package dbt_pkg;
   typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_END, RUN_BEGIN} dbt_run_t;
   typedef logic [15:0] dbt_word_t;
endpackage : dbt_pkg

// >>> dbt_fifo_if.sv
// carrier between the trace logic and its capture fifo
`timescale 1ns/10ps
interface dbt_fifo_if #(
   parameter int W  = 16,
   parameter int CW = 4
);
   logic          inValid;
   logic          inReady;
   logic [W-1:0]  inData;
   logic          outValid;
   logic          outReady;
   logic [W-1:0]  outData;
   logic          flush;
   logic [CW-1:0] count;
   modport src   (output inValid, inData, outReady, flush,
                  input  inReady, outValid, outData, count);
   modport store (input  inValid, inData, outReady, flush,
                  output inReady, outValid, outData, count);
endinterface : dbt_fifo_if

// >>> dbt_fifo.sv
// trace capture fifo with valid/ready on both sides
`timescale 1ns/10ps
module dbt_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input wire logic     sys_clk,
   input wire logic     rstn,
   dbt_fifo_if.store    f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] rdPtr;
   logic [AW-1:0] wrPtr;
   logic [AW:0]   count;

   // pointer step with wrap for any depth
   function automatic logic [AW-1:0] stepPtr(input logic [AW-1:0] p);
      stepPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : stepPtr

   // handshakes; a pop frees room for a push in the same cycle
   wire doPush = f.inValid & f.inReady;
   wire doPop  = f.outValid & f.outReady;
   assign f.inReady  = (count != (AW + 1)'(DEPTH)) | f.outReady;
   assign f.outValid = (count != '0);
   assign f.outData  = mem[rdPtr];
   assign f.count    = count;

   // storage, no reset needed
   always_ff @(posedge sys_clk) begin
      if (doPush) mem[wrPtr] <= f.inData;
   end

   // pointers and occupancy
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdPtr <= '0;
         wrPtr <= '0;
         count <= '0;
      end else if (f.flush) begin
         rdPtr <= '0;
         wrPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) wrPtr <= stepPtr(wrPtr);
         if (doPop) rdPtr <= stepPtr(rdPtr);
         count <= count + (AW + 1)'(doPush) - (AW + 1)'(doPop);
      end
   end
endmodule : dbt_fifo

// >>> dbt_cpu_model.sv
// cpu bus partner model feeding the comparators
`timescale 1ns/10ps
module dbt_cpu_model (
   input  wire logic        sys_clk,
   output logic             cpuBusCycle,
   output logic             cpuRw,
   output logic             cpuOpFetch,
   output logic [15:0]      cpuAddr,
   output logic [7:0]       cpuData
);
   // quiet bus at time zero
   initial begin
      cpuBusCycle = 1'b0;
      cpuRw       = 1'b1;
      cpuOpFetch  = 1'b0;
      cpuAddr     = 16'h0000;
      cpuData     = 8'h00;
   end
   // one bus cycle, then an idle cycle with inverted lines so stale values never match
   task cycle(input logic [15:0] a, input logic rw, input logic op, input logic [7:0] d);
      cpuBusCycle = 1'b1;
      cpuRw       = rw;
      cpuOpFetch  = op;
      cpuAddr     = a;
      cpuData     = d;
      @(posedge sys_clk);
      #2;
      cpuBusCycle = 1'b0;
      cpuOpFetch  = 1'b0;
      cpuAddr     = ~a;
      cpuData     = ~d;
      @(posedge sys_clk);
      #2;
   endtask : cycle
endmodule : dbt_cpu_model

// >>> test_dbt_trace_regs.sv
// self-checking bench for the debug trace registers
`timescale 1ns/10ps
module test_dbt_trace_regs;
   logic        sys_clk, rstn, regWr, regRd, bdcSel, bdcWr, bdcRd, rdSeen, bdSeen;
   logic [3:0]  regSel, fifoCount;
   logic [7:0]  regWdata, regRdata, d [8];
   logic [15:0] bdcWdata, bdcRdata, ca, cb, bp, pa [12];
   logic [31:0] cc;
   logic        serialBkptEnable, bkptKindSelect, mcuSecure, trgEventOnly;
   logic        trgBegin, trgOpQualify, cpuBreakForce, cpuBreakTag, mcuResetReq, runActive;
   logic        cpuBusCycle, cpuRw, cpuOpFetch;
   logic [15:0] cpuAddr;
   logic [7:0]  cpuData;
   logic [8:0]  note;
   logic [1:0]  pulse;
   logic [8:0]  rdQ [$];
   logic [15:0] bdQ [$];
   logic [1:0]  brkQ [$];
   logic [1:0]  rstQ [$];
   int          errors, comparisons, i, k;

   dbt_trace_regs uut (.sys_clk(sys_clk), .rstn(rstn), .regSel(regSel), .regWr(regWr),
      .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .bdcSel(bdcSel),
      .bdcWr(bdcWr), .bdcRd(bdcRd), .bdcWdata(bdcWdata), .bdcRdata(bdcRdata),
      .serialBkptEnable(serialBkptEnable), .bkptKindSelect(bkptKindSelect),
      .mcuSecure(mcuSecure), .trgEventOnly(trgEventOnly), .trgBegin(trgBegin),
      .trgOpQualify(trgOpQualify), .cpuBusCycle(cpuBusCycle), .cpuRw(cpuRw),
      .cpuOpFetch(cpuOpFetch), .cpuAddr(cpuAddr), .cpuData(cpuData),
      .cpuBreakForce(cpuBreakForce), .cpuBreakTag(cpuBreakTag),
      .mcuResetReq(mcuResetReq), .runActive(runActive), .fifoCount(fifoCount));
   dbt_cpu_model cpu (.sys_clk(sys_clk), .cpuBusCycle(cpuBusCycle), .cpuRw(cpuRw),
      .cpuOpFetch(cpuOpFetch), .cpuAddr(cpuAddr), .cpuData(cpuData));

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task tick;
      @(posedge sys_clk);
      #2;
   endtask : tick
   task chkData(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chkData
   task chkPulse(input string n, input logic [1:0] e, input logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask : chkPulse
   // strobes drop for a cycle between accesses
   task regWrite(input logic [3:0] s, input logic [7:0] v);
      regSel = s;
      regWdata = v;
      regWr = 1'b1;
      tick();
      regWr = 1'b0;
      tick();
   endtask : regWrite
   task regRead(input logic [3:0] s, input logic [7:0] e, input logic c);
      regSel = s;
      rdQ.push_back({c, e});
      regRd = 1'b1;
      tick();
      regRd = 1'b0;
      tick();
   endtask : regRead
   task bdcAccess(input logic s, input logic w, input logic [15:0] v);
      bdcSel = s;
      bdcWdata = v;
      if (w) bdcWr = 1'b1;
      else bdcRd = 1'b1;
      if (!w) bdQ.push_back(v);
      tick();
      bdcWr = 1'b0;
      bdcRd = 1'b0;
      tick();
   endtask : bdcAccess
   task wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   // note which edges took a read
   always @(posedge sys_clk) begin
      rdSeen <= regRd;
      bdSeen <= bdcRd;
   end
   // results and pulses are matched against the oldest note
   always @(negedge sys_clk) begin
      if (rdSeen) begin
         note = rdQ.pop_front();
         if (note[8]) chkData("regRdata", {8'h00, note[7:0]}, {8'h00, regRdata});
      end
      if (bdSeen) chkData("bdcRdata", bdQ.pop_front(), bdcRdata);
      if (cpuBreakForce | cpuBreakTag) begin
         pulse = brkQ.size() ? brkQ.pop_front() : 2'b00;
         chkPulse("break", pulse, {cpuBreakForce, cpuBreakTag});
      end
      if (mcuResetReq) begin
         pulse = rstQ.size() ? rstQ.pop_front() : 2'b00;
         chkPulse("reset", pulse, 2'b01);
      end
   end

   // watchdog
   initial begin
      #(25 * 6000);
      errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      {rstn, regWr, regRd, bdcSel, bdcWr, bdcRd, rdSeen, bdSeen} = 8'h00;
      {regSel, regWdata, bdcWdata} = 28'h0000000;
      {serialBkptEnable, bkptKindSelect, mcuSecure, trgEventOnly} = 4'h0;
      {trgBegin, trgOpQualify, errors, comparisons} = 0;
      void'($urandom(24067));
      repeat (2) @(posedge sys_clk);
      #2 rstn = 1'b1;
      tick();
      for (i = 0; i < 16; i++) if (i != 4 && i != 5) regRead(4'(i), 8'h00, 1'b1);
      regWrite(4'h9, 8'h01);
      regRead(4'h9, 8'h00, 1'b1);
      $display("test reset values done");
      ca = 16'($urandom);
      cb = ~ca;
      cc = {ca, cb};
      for (i = 0; i < 4; i++) regWrite(4'(i), cc[31 - 8 * i -: 8]);
      for (i = 0; i < 4; i++) regRead(4'(i), cc[31 - 8 * i -: 8], 1'b1);
      $display("test comparators done");
      for (i = 0; i < 12; i++) begin
         pa[i] = 16'($urandom);
         k = (i >= 8) ? i - 8 : 0;
         cpu.cycle(pa[i], 1'b1, 1'b1, 8'h00);
         regRead(4'h4, pa[k][15:8], i >= 8);
         regRead(4'h5, pa[k][7:0], i >= 8);
      end
      chkData("fifoCount", 16'h0008, {12'h000, fifoCount});
      $display("test profiling done");
      bp = 16'($urandom);
      bdcAccess(1'b0, 1'b1, bp);
      bdcAccess(1'b0, 1'b0, bp);
      bdcAccess(1'b1, 1'b0, 16'h0000);
      bdcAccess(1'b1, 1'b1, 16'hfffe);
      rstQ.push_back(2'b01);
      bdcAccess(1'b1, 1'b1, 16'h0001);
      {serialBkptEnable, bkptKindSelect} = 2'b11;
      brkQ.push_back(2'b10);
      cpu.cycle(bp, 1'b1, 1'b1, 8'h00);
      bkptKindSelect = 1'b0;
      brkQ.push_back(2'b01);
      cpu.cycle(bp, 1'b1, 1'b1, 8'h00);
      serialBkptEnable = 1'b0;
      cpu.cycle(bp, 1'b1, 1'b1, 8'h00);
      $display("test serial port done");
      mcuSecure = 1'b1;
      regWrite(4'h6, 8'h80);
      regRead(4'h6, 8'h00, 1'b1);
      mcuSecure = 1'b0;
      regWrite(4'h6, 8'hc0);
      regWrite(4'h6, 8'h80);
      regRead(4'h6, 8'h80, 1'b1);
      regWrite(4'h6, 8'hd0);
      regRead(4'h6, 8'hd0, 1'b1);
      chkData("runActive", 16'h0001, {15'h0000, runActive});
      regWrite(4'h0, ~ca[15:8]);
      regRead(4'h0, ca[15:8], 1'b1);
      cpu.cycle(cb, 1'b1, 1'b1, 8'h00);
      regRead(4'h5, cb[7:0], 1'b1);
      chkData("fifoCount", 16'h0001, {12'h000, fifoCount});
      brkQ.push_back(2'b10);
      cpu.cycle(ca, 1'b0, 1'b0, 8'h00);
      regRead(4'h6, 8'h90, 1'b1);
      regWrite(4'h6, 8'hfc);
      cpu.cycle(ca, 1'b0, 1'b0, 8'h00);
      brkQ.push_back(2'b01);
      cpu.cycle(ca, 1'b1, 1'b0, 8'h00);
      regRead(4'h6, 8'hbc, 1'b1);
      $display("test end trace done");
      {trgBegin, trgOpQualify} = 2'b11;
      regWrite(4'h6, 8'hd0);
      cpu.cycle(ca, 1'b1, 1'b0, 8'h00);
      cpu.cycle(ca, 1'b1, 1'b1, 8'h00);
      brkQ.push_back(2'b10);
      for (i = 0; i < 8; i++) begin
         pa[i] = 16'($urandom);
         cpu.cycle(pa[i], 1'b1, 1'b1, 8'h00);
      end
      regRead(4'h6, 8'h90, 1'b1);
      regRead(4'h4, pa[0][15:8], 1'b1);
      regRead(4'h5, pa[0][7:0], 1'b1);
      $display("test begin trace done");
      trgEventOnly = 1'b1;
      regWrite(4'h6, 8'hc3);
      cpu.cycle(cb, 1'b0, 1'b0, 8'h5a);
      for (i = 0; i < 8; i++) begin
         d[i] = 8'($urandom);
         cpu.cycle(cb, 1'b1, 1'b0, d[i]);
      end
      regRead(4'h6, 8'h83, 1'b1);
      regWrite(4'h4, 8'hff);
      regRead(4'h4, 8'h00, 1'b1);
      for (i = 0; i < 8; i++) regRead(4'h5, d[i], 1'b1);
      $display("test event capture done");
      tick();
      while (brkQ.size()) chkPulse("break", brkQ.pop_front(), 2'b00);
      while (rstQ.size()) chkPulse("reset", rstQ.pop_front(), 2'b00);
      wrap_up();
   end
endmodule : test_dbt_trace_regs
